// [include/gpio_pkg.sv]
// Package: register map, field layout and carrier types for the six-pin port
package gpio_pkg;
    localparam int          NUM_PINS          = 6;
    localparam int          ADDR_W            = 12;
    localparam logic [11:0] OFF_PIN_CONFIG    = 12'h1E0;
    localparam logic [11:0] OFF_PIN_DATA_DIR  = 12'h1E4;
    localparam logic [11:0] OFF_IRQ_STATUS    = 12'h1E8;
    localparam logic [11:0] OFF_IRQ_MASK      = 12'h1EC;
    localparam logic [11:0] OFF_LAMP_ENABLE   = 12'h1F0;
    localparam int          POS_LOW_FIELD     = 0;
    localparam int          POS_HIGH_FIELD    = 16;
    localparam logic [5:0]  RST_FIELD         = 6'h00;
    localparam logic [31:0] RST_RDATA         = 32'h0000_0000;

    // Pin-side bundle: output value and output enable per pin
    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe;
    } pin_drive_t;

    typedef struct packed {
        logic [5:0] polarity;
        logic [5:0] driver_type;
    } pin_cfg_t;

    typedef struct packed {
        logic [5:0] direction;
        logic [5:0] data;
    } pin_dd_t;
endpackage

// [rtl/gpio_port.sv]
// Six-pin general purpose port with APB registers and level interrupt
`timescale 1ns/100ps
// Notes on behaviour
// - Config bits 21:16 set trigger polarity.
// - Pin at trigger level sets status.
// - Config bits 5:0: zero open-drain.
// - Open-drain drives low only for zero.
// - Direction bits 21:16: one means output.
// - Output pins drive written data bits.
// - Input pin reads return synced level.
// - Output pin reads return written value.
// - Write one clears status; enabled feeds summary.
// - Lamp function enabled overrides pin control.
module gpio_port (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [gpio_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic [5:0]                   pin_in,
    input  wire gpio_pkg::pin_drive_t         lamp_drive,
    output gpio_pkg::pin_drive_t              pin_drive,
    output logic      [5:0]                   pin_irq_polarity,
    output logic      [5:0]                   lamp_function_enable,
    output logic                              irq
);
    import gpio_pkg::*;

    pin_cfg_t    cfg_q, cfg_d;
    pin_dd_t     dd_q, dd_d;
    logic [5:0]  sts_q, sts_d;
    logic [5:0]  mask_q, mask_d;
    logic [5:0]  lamp_q, lamp_d;
    logic [5:0]  sync1_q, sync2_q;
    logic [1:0]  fill_q, fill_d;
    logic        sel_cfg;
    logic        sel_dd;
    logic        sel_sts;
    logic        sel_mask;
    logic        sel_lamp;
    logic [31:0] rdata_q, rdata_d;
    logic        ready_q, ready_d;
    logic        err_q, err_d;
    logic        irq_q, irq_d;
    pin_drive_t  drive_q, drive_d;
    logic        access;
    logic        wr;
    logic        rd;
    logic        mapped;
    logic [5:0]  hit;
    logic [5:0]  rd_data;

    // Single-cycle wait state: answer one cycle after the access phase starts
    assign access = psel && penable && !ready_q;
    assign wr     = access && pwrite;
    assign rd     = access && !pwrite;
    assign mapped = (paddr == OFF_PIN_CONFIG) || (paddr == OFF_PIN_DATA_DIR) ||
                    (paddr == OFF_IRQ_STATUS) || (paddr == OFF_IRQ_MASK) ||
                    (paddr == OFF_LAMP_ENABLE);

    // two-flop sync; first stage only feeds the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= RST_FIELD;
            sync2_q <= RST_FIELD;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_PINS; i++) begin : g_pin
            assign hit[i] = fill_q[1] && (sync2_q[i] == cfg_q.polarity[i]);
            assign rd_data[i] = dd_q.direction[i] ? dd_q.data[i] : sync2_q[i];
            always_comb begin
                if (lamp_q[i]) begin
                    drive_d.out[i] = lamp_drive.out[i];
                    drive_d.oe[i]  = lamp_drive.oe[i];
                end else if (!dd_q.direction[i]) begin
                    drive_d.out[i] = 1'b0;
                    drive_d.oe[i]  = 1'b0;
                end else if (cfg_q.driver_type[i]) begin
                    drive_d.out[i] = dd_q.data[i];
                    drive_d.oe[i]  = 1'b1;
                end else begin
                    drive_d.out[i] = 1'b0;
                    drive_d.oe[i]  = ~dd_q.data[i];
                end
            end
        end
    endgenerate

    // Elaboration guard: every register field is six bits wide
    if (NUM_PINS != 6) begin : g_bad_pins
        $error("pin count must equal the six-bit register fields");
    end

    // Address decode, shared by all register groups
    always_comb begin
        sel_cfg  = (paddr == OFF_PIN_CONFIG);
        sel_dd   = (paddr == OFF_PIN_DATA_DIR);
        sel_sts  = (paddr == OFF_IRQ_STATUS);
        sel_mask = (paddr == OFF_IRQ_MASK);
        sel_lamp = (paddr == OFF_LAMP_ENABLE);
    end

    // Fill flag: synchroniser holds reset zeros, not pin levels, for two edges
    // Without it a low-trigger pin would raise a false status right after reset
    always_comb begin
        fill_d = {fill_q[0], 1'b1};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_q <= 2'b00;
        end else begin
            fill_q <= fill_d;
        end
    end

    always_comb begin
        cfg_d = cfg_q;
        if (wr && sel_cfg) begin
            cfg_d.polarity    = pwdata[POS_HIGH_FIELD +: 6];
            cfg_d.driver_type = pwdata[POS_LOW_FIELD +: 6];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q.polarity    <= RST_FIELD;
            cfg_q.driver_type <= RST_FIELD;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    always_comb begin
        dd_d = dd_q;
        if (wr && sel_dd) begin
            dd_d.direction = pwdata[POS_HIGH_FIELD +: 6];
            dd_d.data      = pwdata[POS_LOW_FIELD +: 6];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dd_q.direction <= RST_FIELD;
            dd_q.data      <= RST_FIELD;
        end else begin
            dd_q <= dd_d;
        end
    end

    // Interrupt mask
    always_comb begin
        mask_d = mask_q;
        if (wr && sel_mask) begin
            mask_d = pwdata[POS_LOW_FIELD +: 6];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= RST_FIELD;
        end else begin
            mask_q <= mask_d;
        end
    end

    always_comb begin
        lamp_d = lamp_q;
        if (wr && sel_lamp) begin
            lamp_d = pwdata[POS_LOW_FIELD +: 6];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamp_q <= RST_FIELD;
        end else begin
            lamp_q <= lamp_d;
        end
    end

    // write-one clear; read also clears; set wins
    always_comb begin
        sts_d = sts_q;
        if (wr && sel_sts) begin
            sts_d = sts_d & ~pwdata[POS_LOW_FIELD +: 6];
        end
        if (rd && sel_sts) begin
            sts_d = RST_FIELD;
        end
        sts_d = sts_d | hit;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= RST_FIELD;
        end else begin
            sts_q <= sts_d;
        end
    end

    // Bus answer: one wait state, pready the cycle after the access edge
    always_comb begin
        rdata_d = rdata_q;
        err_d   = 1'b0;
        ready_d = access;
        if (access) begin
            err_d   = !mapped;
            rdata_d = RST_RDATA;
            if (rd) begin
                case (paddr)
                    OFF_PIN_CONFIG: begin
                        rdata_d[POS_HIGH_FIELD +: 6] = cfg_q.polarity;
                        rdata_d[POS_LOW_FIELD +: 6]  = cfg_q.driver_type;
                    end
                    OFF_PIN_DATA_DIR: begin
                        rdata_d[POS_HIGH_FIELD +: 6] = dd_q.direction;
                        rdata_d[POS_LOW_FIELD +: 6]  = rd_data;
                    end
                    OFF_IRQ_STATUS: begin
                        rdata_d[POS_HIGH_FIELD +: 6] = mask_q;
                        rdata_d[POS_LOW_FIELD +: 6]  = sts_q;
                    end
                    OFF_IRQ_MASK:    rdata_d[POS_LOW_FIELD +: 6] = mask_q;
                    OFF_LAMP_ENABLE: rdata_d[POS_LOW_FIELD +: 6] = lamp_q;
                    default:         rdata_d = RST_RDATA;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= RST_RDATA;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q   <= err_d;
        end
    end

    always_comb begin
        irq_d = |(sts_q & mask_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // Pin drive registered so the pins never see decode glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_q <= '0;
        end else begin
            drive_q <= drive_d;
        end
    end

    assign prdata               = rdata_q;
    assign pready               = ready_q;
    assign pslverr              = err_q;
    assign pin_drive            = drive_q;
    assign pin_irq_polarity     = cfg_q.polarity;
    assign lamp_function_enable = lamp_q;
    assign irq                  = irq_q;
endmodule

// [tb/gpio_port_props.sv]
// Port checker for the six-pin port
`timescale 1ns/100ps
module gpio_port_props (
    input wire logic                        pclk, presetn, psel, penable, pwrite, pready, irq,
    input wire logic [gpio_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                 pwdata, prdata,
    input wire gpio_pkg::pin_drive_t        pin_drive,
    input wire logic [5:0]                  pin_irq_polarity, lamp_function_enable
);
    import gpio_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic take, wcfg, wdd;
    assign take = psel && penable && !pready;
    assign wcfg = take && pwrite && paddr == OFF_PIN_CONFIG;
    assign wdd  = take && pwrite && paddr == OFF_PIN_DATA_DIR && lamp_function_enable == 6'h00;
    a_answer_pulse: assert property (take |=> pready ##1 !pready)
        else $error("answer is not a single pulse after the access");
    a_polarity_write: assert property (wcfg |=> pin_irq_polarity == $past(pwdata[21:16]))
        else $error("polarity differs from written value");
    a_polarity_held: assert property (!wcfg |=> $stable(pin_irq_polarity))
        else $error("polarity moved without a write");
    a_reset_quiet: assert property ($rose(presetn) |-> pin_drive == 12'h000 && !irq && pin_irq_polarity == 6'h00)
        else $error("outputs not idle after reset");
    a_input_released: assert property (wdd |=> ##1 (pin_drive.oe & ~$past(pwdata[21:16], 2)) == 6'h00)
        else $error("input pin is being driven");
    a_output_data: assert property (wdd |=> ##1 (pin_drive.out & ~$past(pwdata[5:0], 2)) == 6'h00)
        else $error("pin drives a level that was not written");
    a_reserved_zero: assert property (pready && !pwrite |-> prdata[31:22] == 10'h000 && prdata[15:6] == 10'h000)
        else $error("reserved read bits not zero");
    a_drive_steady: assert property (!$past(take, 2) && lamp_function_enable == 6'h00
        && $past(lamp_function_enable, 2) == 6'h00 |-> $stable(pin_drive))
        else $error("pin drive changed without a write");
endmodule

// [tb/pin_board.sv]
// Board model: pull-ups and an external driver on the six pins
`timescale 1ns/100ps
module pin_board (
    input  wire gpio_pkg::pin_drive_t pin_drive,
    input  wire logic [5:0]           ext_oe,
    input  wire logic [5:0]           ext_val,
    output logic      [5:0]           pin_in
);
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pin_in[i] = pin_drive.oe[i] ? pin_drive.out[i] : (ext_oe[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule

// [tb/six_pin_gpio_config_data_tb.sv]
// Self-checking bench for the six-pin port
`timescale 1ns/100ps
module six_pin_gpio_config_data_tb;
    import gpio_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r = 32'h274556FB;
    logic [5:0]  pin_in, pin_irq_polarity, lamp_function_enable, d, ext_oe = 6'h00, ext_val = 6'h00;
    pin_drive_t  lamp_drive = 12'h000, pin_drive;
    logic [32:0] q[$];
    int          num_errors = 0, checks = 0;
    always #4 pclk = ~pclk;
    gpio_port u_gpio_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pin_in, .lamp_drive, .pin_drive, .pin_irq_polarity, .lamp_function_enable, .irq);
    pin_board u_pin_board (.pin_drive, .ext_oe, .ext_val, .pin_in);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] dat, input logic [32:0] e);
        if (!w) q.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge pclk) if (pready === 1'b1 && pwrite === 1'b0) chk({pslverr, prdata}, q.pop_front());
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(OFF_PIN_CONFIG, 1'b0, 32'h0, 33'h0);
        apb(OFF_PIN_DATA_DIR, 1'b0, 32'h0, 33'h3F);
        r = lfsr(r);
        apb(OFF_PIN_CONFIG, 1'b1, r & 32'h003F003F, 33'h0);
        apb(OFF_PIN_CONFIG, 1'b0, 32'h0, {1'b0, r & 32'h003F003F});
        chk(33'(pin_irq_polarity), 33'(r[21:16]));
        $display("test reset and config done");
        for (int t = 0; t < 2; t++) begin
            r = lfsr(r);
            d = r[5:0];
            apb(OFF_PIN_CONFIG, 1'b1, t ? 32'h3F : 32'h0, 33'h0);
            apb(OFF_PIN_DATA_DIR, 1'b1, {16'h003F, 10'h000, d}, 33'h0);
            @(posedge pclk);
            chk(33'(pin_drive), t ? {21'h0, d, 6'h3F} : {27'h0, ~d});
            apb(OFF_PIN_DATA_DIR, 1'b0, 32'h0, {17'h0003F, 10'h000, d});
        end
        r = lfsr(r);
        ext_oe <= 6'h30;
        ext_val <= r[5:0];
        apb(OFF_PIN_DATA_DIR, 1'b1, 32'h000F003F, 33'h0);
        repeat (3) @(posedge pclk);
        apb(OFF_PIN_DATA_DIR, 1'b0, 32'h0, {17'h0000F, 10'h000, r[5:4], 4'hF});
        $display("test pin drive done");
        ext_oe <= 6'h01;
        ext_val <= 6'h01;
        apb(OFF_PIN_DATA_DIR, 1'b1, 32'h0, 33'h0);
        apb(OFF_PIN_CONFIG, 1'b1, 32'h00010000, 33'h0);
        apb(OFF_IRQ_STATUS, 1'b1, 32'h3F, 33'h0);
        apb(OFF_IRQ_MASK, 1'b1, 32'h3F, 33'h0);
        repeat (4) @(posedge pclk);
        chk(33'(irq), 33'h1);
        apb(OFF_IRQ_STATUS, 1'b0, 32'h0, 33'h003F0001);
        ext_val <= 6'h00;
        repeat (4) @(posedge pclk);
        apb(OFF_IRQ_STATUS, 1'b1, 32'h01, 33'h0);
        repeat (4) @(posedge pclk);
        chk(33'(irq), 33'h0);
        $display("test interrupt done");
        lamp_drive <= r[11:0];
        apb(OFF_LAMP_ENABLE, 1'b1, 32'h3F, 33'h0);
        @(posedge pclk);
        chk(33'(pin_drive), 33'(lamp_drive));
        apb(12'h1F8, 1'b0, 32'h0, {1'b1, 32'h0});
        $display("test lamp and unmapped done");
        print_verdict();
    end
endmodule
bind gpio_port gpio_port_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .irq, .paddr,
    .pwdata, .prdata, .pin_drive, .pin_irq_polarity, .lamp_function_enable);
